// >>> shared/ievf_pkg.sv
package ievf_pkg;
    // Register byte addresses on the APB bus
    localparam logic [7:0]  ADDR_STATUS  = 8'h00;
    localparam logic [7:0]  ADDR_CONTROL = 8'h04;
    localparam logic [7:0]  ADDR_BUFFER  = 8'h08;

    // Event status field positions
    localparam int          ST_TXC_BIT   = 1;
    localparam int          ST_RXR_BIT   = 2;
    localparam int          ST_STR_BIT   = 3;

    // Control field positions
    localparam int          CT_IEN_BIT   = 0;
    localparam int          CT_STREN_BIT = 1;
    localparam int          CT_SCL_BIT   = 8;

    // Buffer lanes
    localparam int          BUF_DATA_W   = 8;
    localparam int          BUF_ADDR_W   = 7;
    localparam int          BUF_USED_W   = 10;

    // Values after reset
    localparam logic [15:0] STATUS_RST   = 16'h0000;
    localparam logic [15:0] BUFFER_RST   = 16'h0000;
    localparam logic [1:0]  CONTROL_RST  = 2'h0;

    // Link sampler depth
    localparam int          SYNC_STAGES  = 2;
endpackage : ievf_pkg

// >>> shared/ievf_link_if.sv
`timescale 1ns/1ns
interface ievf_link_if;
    logic scl_level;
    logic scl_fall;

    modport sampler (output scl_level, output scl_fall);
    modport user    (input  scl_level, input  scl_fall);
endinterface : ievf_link_if

// >>> core/ievf_scl_sampler.sv
`timescale 1ns/1ns
module ievf_scl_sampler (
    input  wire logic    mclk,
    input  wire logic    rst,
    input  wire logic    scl_i,
    ievf_link_if.sampler link
);
    logic [ievf_pkg::SYNC_STAGES-1:0] sync_r;
    logic                             last_r;

    // First stage feeds only the second; edges use settled copies
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_r <= '1;
            last_r <= 1'b1;
        end else begin
            sync_r <= {sync_r[ievf_pkg::SYNC_STAGES-2:0], scl_i};
            last_r <= sync_r[ievf_pkg::SYNC_STAGES-1];
        end
    end

    assign link.scl_level = sync_r[ievf_pkg::SYNC_STAGES-1];
    assign link.scl_fall  = last_r & ~sync_r[ievf_pkg::SYNC_STAGES-1];
endmodule : ievf_scl_sampler

// >>> core/ievf_status.sv
`timescale 1ns/1ns
module ievf_status (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        byte_done,
    input  wire logic        ack_received,
    input  wire logic        byte_received,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        stretch_point,
    input  wire logic        addr_phase,
    input  wire logic        busy,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    output logic [7:0]       tx_byte,
    output logic             irq
);
    ievf_link_if link ();

    ievf_scl_sampler u_sampler (
        .mclk  (mclk),
        .rst   (rst),
        .scl_i (scl_i),
        .link  (link.sampler)
    );

    logic        txc_r;
    logic        txc_nxt;
    logic        rxr_r;
    logic        rxr_nxt;
    logic        str_r;
    logic        str_nxt;
    logic        ack_wait_r;
    logic        ack_wait_nxt;
    logic        ien_r;
    logic        stren_r;
    logic [15:0] buf_r;
    logic [15:0] buf_nxt;
    logic [31:0] prdata_r;
    logic [7:0]  tx_byte_r;
    logic        scl_hold_r;

    // Bus decode
    wire         setup_ph    = psel & ~penable;
    wire         access_ph   = psel & penable;
    wire         hit_status  = paddr == ievf_pkg::ADDR_STATUS;
    wire         hit_control = paddr == ievf_pkg::ADDR_CONTROL;
    wire         hit_buffer  = paddr == ievf_pkg::ADDR_BUFFER;
    wire         mapped      = hit_status | hit_control | hit_buffer;
    wire         wr_ok       = access_ph & pwrite & mapped;
    wire         wr_status   = wr_ok & hit_status;
    wire         wr_control  = wr_ok & hit_control;
    wire         wr_buffer   = wr_ok & hit_buffer;

    // Zero-wait slave: answer in the access cycle
    assign pready  = access_ph;
    assign pslverr = access_ph & ~mapped;
    assign prdata  = prdata_r;

    wire         sw_txc      = pwdata[ievf_pkg::ST_TXC_BIT];
    wire         sw_rxr      = pwdata[ievf_pkg::ST_RXR_BIT];
    wire         sw_str      = pwdata[ievf_pkg::ST_STR_BIT];

    wire [15:0]  status_view = {12'h000, str_r, rxr_r, txc_r, 1'b0};
    wire [15:0]  ctrl_view   = {7'h00, link.scl_level, 6'h00,
                                stren_r, ien_r};
    wire [15:0]  buf_view    = {6'h00,
                                buf_r[ievf_pkg::BUF_USED_W-1:0]};
    wire [15:0]  rd_sel      = hit_status  ? status_view :
                               hit_control ? ctrl_view   :
                               hit_buffer  ? buf_view    : 16'h0000;

    // Acknowledge pairs with the byte that went before it
    assign ack_wait_nxt = byte_done ? 1'b1 :
                          ack_received ? 1'b0 : ack_wait_r;
    wire   txc_hw_set   = ack_wait_r & ack_received;

    // Hardware set wins over a same-cycle software clear
    always_comb begin
        txc_nxt = txc_r;
        if (wr_status) begin
            txc_nxt = sw_txc;
        end
        if (txc_hw_set) begin
            txc_nxt = 1'b1;
        end
    end

    always_comb begin
        rxr_nxt = rxr_r;
        if (wr_status && !sw_rxr) begin
            rxr_nxt = 1'b0;
        end
        if (byte_received) begin
            rxr_nxt = 1'b1;
        end
    end

    wire   str_hw_set = stren_r & stretch_point;

    always_comb begin
        str_nxt = str_r;
        if (wr_status && !sw_str) begin
            str_nxt = 1'b0;
        end
        if (str_hw_set) begin
            str_nxt = 1'b1;
        end
    end

    // Received byte overrides a racing software write
    always_comb begin
        buf_nxt = buf_r;
        if (wr_buffer && !busy) begin
            buf_nxt = {6'h00, pwdata[ievf_pkg::BUF_USED_W-1:0]};
        end
        if (byte_received) begin
            buf_nxt = {buf_r[15:ievf_pkg::BUF_DATA_W], rx_byte};
        end
    end

    // Address phase sends seven bits, bit 7 left to the shifter
    wire [7:0] tx_sel = addr_phase ?
        {1'b0, buf_r[ievf_pkg::BUF_ADDR_W-1:0]} :
        buf_r[ievf_pkg::BUF_DATA_W-1:0];

    always_ff @(posedge mclk) begin
        if (rst) begin
            txc_r      <= ievf_pkg::STATUS_RST[ievf_pkg::ST_TXC_BIT];
            rxr_r      <= ievf_pkg::STATUS_RST[ievf_pkg::ST_RXR_BIT];
            str_r      <= ievf_pkg::STATUS_RST[ievf_pkg::ST_STR_BIT];
            ack_wait_r <= 1'b0;
        end else begin
            txc_r      <= txc_nxt;
            rxr_r      <= rxr_nxt;
            str_r      <= str_nxt;
            ack_wait_r <= ack_wait_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ien_r   <= ievf_pkg::CONTROL_RST[ievf_pkg::CT_IEN_BIT];
            stren_r <= ievf_pkg::CONTROL_RST[ievf_pkg::CT_STREN_BIT];
        end else if (wr_control) begin
            ien_r   <= pwdata[ievf_pkg::CT_IEN_BIT];
            stren_r <= pwdata[ievf_pkg::CT_STREN_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            buf_r     <= ievf_pkg::BUFFER_RST;
            tx_byte_r <= 8'h00;
        end else begin
            buf_r     <= buf_nxt;
            tx_byte_r <= tx_sel;
        end
    end

    // Read data captured in setup so it is steady through access
    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_ph && !pwrite) begin
            prdata_r <= {16'h0000, rd_sel};
        end
    end

    // Hold follows the flag; released only after software clears it
    always_ff @(posedge mclk) begin
        if (rst) begin
            scl_hold_r <= 1'b0;
        end else begin
            scl_hold_r <= str_nxt;
        end
    end

    assign scl_o   = 1'b0;
    assign scl_oe  = scl_hold_r;
    assign tx_byte = tx_byte_r;
    assign irq     = ien_r & (txc_r | rxr_r | str_r);
endmodule : ievf_status

// >>> verification/ievf_status_sva.sv
`timescale 1ns/1ns
module ievf_status_sva (
    input wire logic        mclk, rst, psel, penable, pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic        pready, pslverr, byte_done, ack_received,
    input wire logic        byte_received, stretch_point, addr_phase, busy,
    input wire logic [7:0]  rx_byte, tx_byte,
    input wire logic        scl_i, scl_o, scl_oe, irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire acc = psel && penable;
    wire wr_any = acc && pwrite;
    wire clr_str = wr_any && paddr == ievf_pkg::ADDR_STATUS && !pwdata[3];
    wire odd = !(paddr inside {8'h00, 8'h04, 8'h08});
    a_bad_addr: assert property (acc |-> pslverr == odd)
        else $error("slave error mismatch");
    a_scl_drive: assert property (!scl_o) else $error("scl high");
    a_hold_scl: assert property (scl_oe && !clr_str |=> scl_oe)
        else $error("scl released early");
    a_free_scl: assert property (
        scl_oe && clr_str && !stretch_point |=> !scl_oe)
        else $error("scl not released");
    a_str_cause: assert property (
        $rose(scl_oe) |-> $past(stretch_point))
        else $error("stretch without cause");
    a_irq_keep: assert property (irq && !wr_any |=> irq)
        else $error("irq dropped");
    a_irq_cause: assert property (
        $rose(irq) |-> $past(byte_received || ack_received || wr_any ||
                             stretch_point))
        else $error("irq without cause");
    a_addr_lane: assert property (addr_phase |=> !tx_byte[7])
        else $error("address bit 7 sent");
    c_stretch: cover property ($rose(scl_oe));
    c_irq: cover property ($rose(irq));
    c_error: cover property (acc && pslverr);
endmodule : ievf_status_sva
bind ievf_status ievf_status_sva i_sva (.mclk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .byte_done, .ack_received,
    .byte_received, .stretch_point, .addr_phase, .busy, .rx_byte, .tx_byte,
    .scl_i, .scl_o, .scl_oe, .irq);

// >>> verification/ievf_bus_model.sv
`timescale 1ns/1ns
module ievf_bus_model (
    input  wire logic run,
    input  wire logic scl_o,
    input  wire logic scl_oe,
    output logic      scl_line
);
    logic gen = 1'b1;
    // Odd offset keeps link edges off the system clock grid
    initial begin
        #3;
        forever #40 gen = run ? ~gen : 1'b1;
    end
    // Released line follows gen: high while run is low, toggling while run is set
    assign scl_line = scl_oe ? scl_o : gen;
endmodule : ievf_bus_model

// >>> verification/tb_i2c_status_event_flags.sv
`timescale 1ns/1ns
module tb_i2c_status_event_flags;
    logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        addr_phase = 0, busy = 0, run = 0, e, pready, pslverr;
    logic        scl_o, scl_oe, irq, scl_line;
    logic [3:0]  ev = 4'h0;
    logic [7:0]  paddr = 8'h00, rx_byte = 8'h00, tx_byte;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [9:0]  v;
    int          num_errors = 0, checks_done = 0, cyc = 0;
    integer      seed = 32'h202BA959;
    initial forever #5 mclk = ~mclk;
    ievf_status i_dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .byte_done(ev[0]),
        .ack_received(ev[1]), .byte_received(ev[2]), .rx_byte,
        .stretch_point(ev[3]), .addr_phase, .busy, .scl_i(scl_line),
        .scl_o, .scl_oe, .tx_byte, .irq);
    ievf_bus_model i_bus (.run, .scl_o, .scl_oe, .scl_line);
    function automatic logic [7:0] tx_exp(logic [9:0] b, logic ap);
        return ap ? {1'b0, b[6:0]} : b[7:0];
    endfunction : tx_exp
    task automatic chk(string n, logic [31:0] s, logic [31:0] x);
        checks_done++;
        if (s !== x) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never reassigns psel in this step
        @(posedge mclk);
    endtask : apb
    task automatic rd(logic [7:0] a, logic [31:0] x, string n);
        apb(1'b0, a, 32'h0);
        chk(n, q, x);
    endtask : rd
    task automatic pulse(int k);
        ev[k] <= 1'b1;
        @(posedge mclk);
        ev <= 4'h0;
        repeat (2) @(posedge mclk);
    endtask : pulse
    task automatic ck_out(logic [1:0] x);
        @(negedge mclk);
        chk("irq_scl", {30'h0, irq, scl_oe}, {30'h0, x});
        @(posedge mclk);
    endtask : ck_out
    task automatic print_verdict;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(8'h00, 32'h0, "status");
        rd(8'h04, 32'h100, "control");
        rd(8'h0C, 32'h0, "unmapped");
        chk("slverr", {31'h0, e}, 32'h1);
        apb(1'b1, 8'h04, 32'h3);
        pulse(0);
        pulse(1);
        rd(8'h00, 32'h2, "txc");
        ck_out(2'b10);
        apb(1'b1, 8'h00, 32'h0);
        pulse(1);
        rd(8'h00, 32'h0, "lone ack");
        apb(1'b1, 8'h00, 32'h2);
        ck_out(2'b10);
        apb(1'b1, 8'h00, 32'h0);
        ck_out(2'b00);
        repeat (3) begin
            rx_byte <= 8'($random(seed));
            pulse(2);
            rd(8'h08, {24'h0, rx_byte}, "rx data");
            rd(8'h00, 32'h4, "rxr");
            apb(1'b1, 8'h00, 32'h0);
            apb(1'b1, 8'h00, 32'h4);
            rd(8'h00, 32'h0, "rxr soft");
        end
        apb(1'b1, 8'h04, 32'h1);
        pulse(3);
        ck_out(2'b00);
        apb(1'b1, 8'h04, 32'h3);
        run <= 1'b1;
        repeat (30) @(posedge mclk);
        pulse(3);
        rd(8'h00, 32'h8, "str");
        rd(8'h04, 32'h3, "scl held");
        apb(1'b1, 8'h00, 32'h8);
        ck_out(2'b11);
        apb(1'b1, 8'h00, 32'h0);
        ck_out(2'b00);
        run <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            v = 10'($random(seed));
            addr_phase <= i[0];
            apb(1'b1, 8'h08, {22'h0, v});
            rd(8'h08, {22'h0, v}, "buffer");
            chk("tx", {24'h0, tx_byte}, {24'h0, tx_exp(v, i[0])});
        end
        apb(1'b1, 8'h04, 32'h0);
        pulse(2);
        ck_out(2'b00);
        apb(1'b1, 8'h04, 32'h1);
        ck_out(2'b10);
        print_verdict();
    end
endmodule : tb_i2c_status_event_flags
